//--- design/power_switch_regs.vh
// register layout, addresses and field positions of the power switch slave
`ifndef POWER_SWITCH_REGS_VH
`define POWER_SWITCH_REGS_VH
`define ALERT_RETURN_ADDR   7'h0C
`define CHAN_ADDR_BASE_LO   7'h50
`define CHAN_ADDR_BASE_HI   7'h52
`define CMD_OPERATE_BIT     7
`define CMD_SUPPLY_ON_BIT   6
`define CMD_RAIL_SEL_BIT    5
`define CMD_SUPPLY_FLT_BIT  4
`define CMD_PROG_ON_BIT     3
`define CMD_PROG_HI_BIT     2
`define CMD_PROG_FLT_BIT    1
`define CMD_MASK_BIT        0
`define CMD_RESET           8'h00
`define FAULT_CAT_BIT       7
`define FAULT_RESET         8'h00
`define RETURN_ADDR_RESET   8'h00
`define GLITCH_WIDTH        2
`endif

//--- design/line_sampler.v
// two-flop synchroniser with edge detect for one serial bus line
`timescale 1ns/100ps
`default_nettype none
module line_sampler (
    input  wire sys_clk_in,
    input  wire rst_b_in,
    input  wire line_in,
    output reg  level_out,
    output reg  rise_out,
    output reg  fall_out
);
    reg meta_q;   // first stage, read only by sync_q
    reg sync_q;   // second stage
    // synchronise then compare with previous synced level
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q    <= 1'b1;
            sync_q    <= 1'b1;
            level_out <= 1'b1;
            rise_out  <= 1'b0;
            fall_out  <= 1'b0;
        end else begin
            meta_q    <= line_in;
            sync_q    <= meta_q;
            level_out <= sync_q;
            rise_out  <= sync_q & ~level_out;
            fall_out  <= ~sync_q & level_out;
        end
    end
endmodule
`default_nettype wire

//--- design/power_switch_slave.v
// serial command slave driving the dual card socket power switch states
`timescale 1ns/100ps
`default_nettype none
`include "power_switch_regs.vh"
module power_switch_slave (
    input  wire       sys_clk_in,
    input  wire       rst_b_in,
    input  wire       serial_clock_in,     // bus clock from host
    input  wire       serial_data_in,      // bus data line level
    output reg        serial_data_out,     // always low when enabled
    output reg        serial_data_oe_out,  // high while pulling data low
    output reg        alert_out,           // open drain output value, low
    output reg        alert_oe_out,        // high while alert pulled low
    input  wire       address_strap_in,    // low: grounded, high: tied up
    input  wire       suspend_select_input,
    input  wire [3:0] overcurrent_in,      // supply a, prog a, supply b, prog b
    input  wire       catastrophic_in,     // thermal or undervoltage lockout
    output reg  [1:0] card_supply_on_out,  // per channel {b,a}
    output reg  [1:0] card_rail_select_out,
    output reg  [1:0] card_supply_float_out,
    output reg  [1:0] card_prog_on_out,
    output reg  [1:0] card_prog_high_select_out,
    output reg  [1:0] card_prog_float_out
);
    // protocol states
    localparam [2:0] ST_IDLE  = 3'd0;   // wait for start
    localparam [2:0] ST_ADDR  = 3'd1;   // shift address and direction
    localparam [2:0] ST_ACK   = 3'd2;   // acknowledge slot
    localparam [2:0] ST_WDATA = 3'd3;   // receive command byte
    localparam [2:0] ST_RDATA = 3'd4;   // transmit read byte
    localparam [2:0] ST_MACK  = 3'd5;   // host acknowledge of read byte
    localparam [2:0] ST_DONE  = 3'd6;   // wait for stop
    localparam [2:0] ST_SKIP  = 3'd7;   // not addressed, ignore

    wire scl;        // synced clock level
    wire scl_rise;   // clock rising edge
    wire scl_fall;   // clock falling edge
    wire sda;        // synced data level
    wire sda_rise;   // data rising edge
    wire sda_fall;   // data falling edge

    // clock line sampler
    line_sampler u_clock_sampler (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .line_in    (serial_clock_in),
        .level_out  (scl),
        .rise_out   (scl_rise),
        .fall_out   (scl_fall)
    );
    // data line sampler
    line_sampler u_data_sampler (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .line_in    (serial_data_in),
        .level_out  (sda),
        .rise_out   (sda_rise),
        .fall_out   (sda_fall)
    );

    reg       strap_meta_q;   // strap synchroniser first stage
    reg       strap_q;        // synced strap
    reg       susp_meta_q;    // suspend select first stage
    reg       susp_q;         // synced suspend select
    reg [4:0] flt_meta_q;     // fault inputs first stage
    reg [4:0] flt_q;          // synced fault inputs

    // synchronise the static and fault inputs
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strap_meta_q <= 1'b0;
            strap_q      <= 1'b0;
            susp_meta_q  <= 1'b1;
            susp_q       <= 1'b1;
            flt_meta_q   <= 5'h00;
            flt_q        <= 5'h00;
        end else begin
            strap_meta_q <= address_strap_in;
            strap_q      <= strap_meta_q;
            susp_meta_q  <= suspend_select_input;
            susp_q       <= susp_meta_q;
            flt_meta_q   <= {catastrophic_in, overcurrent_in};
            flt_q        <= flt_meta_q;
        end
    end

    // start and stop detect while clock high
    wire start_det = sda_fall & scl;
    wire stop_det  = sda_rise & scl;

    // addresses selected by strap
    wire [6:0] chan_a_addr = address_strap_in_sel(strap_q);
    wire [6:0] chan_b_addr = chan_a_addr | 7'h01;

    function [6:0] address_strap_in_sel;
        input s;
        begin
            address_strap_in_sel = s ? `CHAN_ADDR_BASE_HI
                                     : `CHAN_ADDR_BASE_LO;
        end
    endfunction

    reg [2:0] state_q;       // protocol state
    reg [3:0] bit_cnt_q;     // bits shifted in current byte
    reg [7:0] shift_q;       // incoming shift register
    reg [7:0] tx_q;          // outgoing byte
    reg       is_write_q;    // direction of current frame
    reg       chan_b_q;      // frame targets channel B
    reg       alert_rd_q;    // frame is return address read
    reg       cmd_ok_q;      // full command byte received
    reg [7:0] cmd_q;         // received command waiting for stop
    reg       ack_after_q;   // next state after ack: 1 done, 0 data phase
    reg [7:0] op_a_q;        // operate latch channel A
    reg [7:0] op_b_q;        // operate latch channel B
    reg [7:0] sus_a_q;       // suspend latch channel A
    reg [7:0] sus_b_q;       // suspend latch channel B
    reg [4:0] fault_q;       // latched faults {cat, f1..f4}
    reg       alert_q;       // latched alert
    reg       fault_rd_pulse;  // fault byte shifted out
    reg       alert_rd_pulse;  // return address served

    // active command per channel, chosen by suspend select
    wire [7:0] act_a = susp_q ? op_a_q : sus_a_q;
    wire [7:0] act_b = susp_q ? op_b_q : sus_b_q;
    wire       mask  = act_a[`CMD_MASK_BIT];

    // decode of a received address byte
    wire [6:0] rx_addr  = shift_q[6:0];
    wire       serial_data_in_bit = sda;
    wire       rx_rd    = serial_data_in_bit;
    wire       hit_a    = rx_addr == chan_a_addr;
    wire       hit_b    = rx_addr == chan_b_addr;
    wire       hit_alrt = (rx_addr == `ALERT_RETURN_ADDR) & rx_rd;
    wire       hit_rd_b = hit_b & rx_rd;   // channel B read not served

    // return address: upper seven bits hold the channel A address
    wire [6:0] chan_a_ret = chan_a_addr;

    // fault status byte, catastrophic flag at bit 7
    wire [7:0] fault_byte = {fault_q[4], fault_q[3:0], 3'b000};

    // serial protocol engine
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q        <= ST_IDLE;
            bit_cnt_q      <= 4'h0;
            shift_q        <= 8'h00;
            tx_q           <= 8'h00;
            is_write_q     <= 1'b0;
            chan_b_q       <= 1'b0;
            alert_rd_q     <= 1'b0;
            cmd_ok_q       <= 1'b0;
            cmd_q          <= `CMD_RESET;
            ack_after_q    <= 1'b0;
            op_a_q         <= `CMD_RESET;
            op_b_q         <= `CMD_RESET;
            sus_a_q        <= `CMD_RESET;
            sus_b_q        <= `CMD_RESET;
            serial_data_oe_out <= 1'b0;
            fault_rd_pulse <= 1'b0;
            alert_rd_pulse <= 1'b0;
        end else begin
            fault_rd_pulse <= 1'b0;
            alert_rd_pulse <= 1'b0;
            if (start_det) begin
                // new start aborts frame, partial data dropped
                state_q            <= ST_ADDR;
                bit_cnt_q          <= 4'h0;
                cmd_ok_q           <= 1'b0;
                serial_data_oe_out <= 1'b0;
            end else if (stop_det) begin
                // stop commits a complete command only
                if (cmd_ok_q) begin
                    case ({chan_b_q, cmd_q[`CMD_OPERATE_BIT]})
                        2'b01:   op_a_q  <= cmd_q;
                        2'b00:   sus_a_q <= cmd_q;
                        2'b11:   op_b_q  <= cmd_q;
                        default: sus_b_q <= cmd_q;
                    endcase
                end
                cmd_ok_q           <= 1'b0;
                state_q            <= ST_IDLE;
                serial_data_oe_out <= 1'b0;
            end else begin
                case (state_q)
                    ST_ADDR: begin
                        // sample on rising clock edge
                        if (scl_rise) begin
                            if (bit_cnt_q == 4'd7) begin
                                is_write_q <= ~sda;
                                chan_b_q   <= hit_b;
                                alert_rd_q <= hit_alrt;
                                if ((hit_a | hit_b | hit_alrt) & ~hit_rd_b)
                                    state_q <= ST_ACK;
                                else
                                    state_q <= ST_SKIP;
                                ack_after_q <= 1'b0;
                                tx_q <= hit_alrt ? {chan_a_ret, 1'b0}
                                                 : fault_byte;
                            end else begin
                                shift_q <= {shift_q[6:0], sda};
                            end
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                    ST_ACK: begin
                        // drive ack low for one clock high
                        if (scl_fall) begin
                            if (!serial_data_oe_out) begin
                                serial_data_oe_out <= 1'b1;
                            end else begin
                                serial_data_oe_out <= 1'b0;
                                bit_cnt_q          <= 4'h0;
                                if (ack_after_q)
                                    state_q <= ST_DONE;
                                else if (is_write_q)
                                    state_q <= ST_WDATA;
                                else begin
                                    state_q <= ST_RDATA;
                                    serial_data_oe_out <= ~tx_q[7];
                                end
                            end
                        end
                    end
                    ST_WDATA: begin
                        // shift in the single command byte
                        if (scl_rise) begin
                            shift_q   <= {shift_q[6:0], sda};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'd7) begin
                                cmd_q       <= {shift_q[6:0], sda};
                                cmd_ok_q    <= 1'b1;
                                ack_after_q <= 1'b1;
                                state_q     <= ST_ACK;
                            end
                        end
                    end
                    ST_RDATA: begin
                        // shift out on falling clock, msb first
                        if (scl_fall) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'd7) begin
                                serial_data_oe_out <= 1'b0;
                                state_q <= ST_MACK;
                                fault_rd_pulse <= ~alert_rd_q;
                                alert_rd_pulse <= alert_rd_q;
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                serial_data_oe_out <= ~tx_q[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        // single byte only; ignore host ack
                        if (scl_fall)
                            state_q <= ST_DONE;
                    end
                    ST_DONE: state_q <= ST_DONE;
                    ST_SKIP: state_q <= ST_SKIP;
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // fault latches and alert: set wins over read clear
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fault_q <= 5'h00;
            alert_q <= 1'b0;
        end else begin
            if (fault_rd_pulse)
                fault_q <= flt_q;
            else if (!alert_q)
                fault_q <= fault_q | flt_q;
            if (alert_rd_pulse)
                alert_q <= |flt_q;
            else if (|flt_q)
                alert_q <= 1'b1;
        end
    end

    // switch states from the applied command per channel
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            card_supply_on_out        <= 2'b00;
            card_rail_select_out      <= 2'b00;
            card_supply_float_out     <= 2'b00;
            card_prog_on_out          <= 2'b00;
            card_prog_high_select_out <= 2'b00;
            card_prog_float_out       <= 2'b00;
            alert_out                 <= 1'b0;
            alert_oe_out              <= 1'b0;
            serial_data_out           <= 1'b0;
        end else begin
            // float overrides on/ground
            card_supply_float_out <= {act_b[`CMD_SUPPLY_FLT_BIT],
                                      act_a[`CMD_SUPPLY_FLT_BIT]};
            card_supply_on_out    <= {act_b[`CMD_SUPPLY_ON_BIT]
                                      & ~act_b[`CMD_SUPPLY_FLT_BIT],
                                      act_a[`CMD_SUPPLY_ON_BIT]
                                      & ~act_a[`CMD_SUPPLY_FLT_BIT]};
            // rail only meaningful while on
            card_rail_select_out  <= {act_b[`CMD_RAIL_SEL_BIT],
                                      act_a[`CMD_RAIL_SEL_BIT]};
            // programming output
            card_prog_float_out   <= {act_b[`CMD_PROG_FLT_BIT],
                                      act_a[`CMD_PROG_FLT_BIT]};
            card_prog_on_out      <= {act_b[`CMD_PROG_ON_BIT]
                                      & ~act_b[`CMD_PROG_FLT_BIT],
                                      act_a[`CMD_PROG_ON_BIT]
                                      & ~act_a[`CMD_PROG_FLT_BIT]};
            // source select while on
            card_prog_high_select_out <= {act_b[`CMD_PROG_HI_BIT],
                                          act_a[`CMD_PROG_HI_BIT]};
            // alert gated by channel A mask
            alert_oe_out          <= alert_q & ~mask;
            alert_out             <= 1'b0;
            serial_data_out       <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- test/power_switch_slave_chk.sv
// port assertions for the power switch slave
`timescale 1ns/100ps
`default_nettype none
module power_switch_slave_chk (
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    input wire logic       serial_clock_in,
    input wire logic       serial_data_out,
    input wire logic       serial_data_oe_out,
    input wire logic       alert_out,
    input wire logic       suspend_select_input,
    input wire logic [1:0] card_supply_on_out,
    input wire logic [1:0] card_rail_select_out,
    input wire logic [1:0] card_supply_float_out,
    input wire logic [1:0] card_prog_on_out,
    input wire logic [1:0] card_prog_high_select_out,
    input wire logic [1:0] card_prog_float_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // every switch state in one vector
    wire [11:0] sw_all = {card_supply_on_out, card_rail_select_out,
        card_supply_float_out, card_prog_on_out,
        card_prog_high_select_out, card_prog_float_out};
    // bus clock low and suspend select steady for a while
    sequence quiet_low;
        (!serial_clock_in && $stable(suspend_select_input)) [*6];
    endsequence
    // device pulling data as the bus clock rises
    sequence ack_at_rise;
        serial_data_oe_out && $rose(serial_clock_in);
    endsequence
    a_reset_outputs_zero: assert property ($rose(rst_b_in) |-> sw_all == 12'h000)
        else $error("switch outputs not grounded after reset");
    a_supply_float_wins: assert property ((card_supply_on_out & card_supply_float_out) == 2'b00)
        else $error("supply on while floated");
    a_prog_float_wins: assert property ((card_prog_on_out & card_prog_float_out) == 2'b00)
        else $error("prog output on while floated");
    a_data_level_low: assert property (serial_data_oe_out |-> serial_data_out == 1'b0)
        else $error("data driven high");
    a_ack_moves_low: assert property ($changed(serial_data_oe_out) |-> !serial_clock_in)
        else $error("data drive changed while bus clock high");
    a_ack_holds_high: assert property (ack_at_rise |-> serial_data_oe_out [*8])
        else $error("data drive dropped during clock high");
    a_outputs_quiet: assert property (quiet_low |-> $stable(sw_all))
        else $error("switch outputs moved mid frame");
    a_alert_level_low: assert property (alert_out == 1'b0)
        else $error("alert driven high");
endmodule
bind power_switch_slave power_switch_slave_chk i_chk (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .serial_clock_in(serial_clock_in), .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out), .alert_out(alert_out),
    .suspend_select_input(suspend_select_input),
    .card_supply_on_out(card_supply_on_out),
    .card_rail_select_out(card_rail_select_out),
    .card_supply_float_out(card_supply_float_out),
    .card_prog_on_out(card_prog_on_out),
    .card_prog_high_select_out(card_prog_high_select_out),
    .card_prog_float_out(card_prog_float_out));
`default_nettype wire

//--- test/smbus_host_model.sv
// behavioural bus host driving serial clock and open drain data
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
    input  wire logic line_in,   // resolved data line level
    output var  logic scl_out,   // bus clock, high when idle
    output var  logic sda_out    // 1 releases, 0 pulls low
);
    // idle bus: both lines released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // one bit: data set in clock low, sampled mid clock high
    task automatic bit_io(input logic b, output logic r);
        sda_out = b;
        #40 scl_out = 1'b1;
        #40 r = line_in;
        #40 scl_out = 1'b0;
        #40;
    endtask
    // whole frame; cut below 8 stops early inside the byte
    task automatic txn(input logic [6:0] a, input logic rd,
                       input logic [7:0] d, input int cut,
                       output logic ak0, output logic ak1,
                       output logic [7:0] q);
        logic r;
        #1.3 sda_out = 1'b0; // start with clock high
        #40 scl_out = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--) bit_io(i > 0 ? a[i-1] : rd, r);
        bit_io(1'b1, r);
        ak0 = !r;
        ak1 = 1'b0;
        q = 8'h00;
        // a single byte follows the address
        for (int i = 7; i >= 8 - cut; i--) begin
            bit_io(rd | d[i], r);
            q[i] = r;
        end
        // host releases the ack slot; on reads that is a nack
        if (cut == 8) begin
            bit_io(1'b1, r);
            ak1 = !r;
        end
        sda_out = 1'b0;
        #40 scl_out = 1'b1;
        #40 sda_out = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

//--- test/power_switch_slave_tb.sv
// self-checking bench for the power switch slave
`timescale 1ns/100ps
`default_nettype none
module power_switch_slave_tb;
    logic       sys_clk_in;   // system clock
    logic       rst_b_in;     // reset, active low
    logic       strap;        // address strap
    logic       susp_sel;     // suspend select
    logic [3:0] ovc;          // overcurrent flags
    logic       cat;          // lockout fault
    logic [7:0] op_l [2];     // expected operate latches
    logic [7:0] sus_l [2];    // expected suspend latches
    integer     seed = 32'hA2F4;
    int         errors = 0;
    int         compares = 0;
    int         cycles = 0;
    wire        scl, host_sda, dout, doe, aout, aoe;
    wire  [1:0] s_on, s_rail, s_flt, p_on, p_hi, p_flt;
    wire        line = host_sda & ~doe; // pulled-up data line
    power_switch_slave i_power_switch_slave (.sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in), .serial_clock_in(scl), .serial_data_in(line),
        .serial_data_out(dout), .serial_data_oe_out(doe), .alert_out(aout),
        .alert_oe_out(aoe), .address_strap_in(strap),
        .suspend_select_input(susp_sel), .overcurrent_in(ovc),
        .catastrophic_in(cat), .card_supply_on_out(s_on),
        .card_rail_select_out(s_rail), .card_supply_float_out(s_flt),
        .card_prog_on_out(p_on), .card_prog_high_select_out(p_hi),
        .card_prog_float_out(p_flt));
    smbus_host_model i_smbus_host_model (.line_in(line), .scl_out(scl),
        .sda_out(host_sda));
    // clock generator
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    // hang guard
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // expected {on, rail, float, prog on, prog high, prog float}
    function automatic logic [7:0] sw_exp(input logic [7:0] c);
        logic so, po;
        so = c[6] & ~c[4];
        po = c[3] & ~c[1];
        return {2'b00, so, c[5] & so, c[4], po, c[2] & po, c[1]};
    endfunction
    // observed states, rail and high select only where on
    function automatic logic [7:0] sw_got(input int c);
        return {2'b00, s_on[c], s_rail[c] & s_on[c], s_flt[c], p_on[c],
                p_hi[c] & p_on[c], p_flt[c]};
    endfunction
    task automatic check_sw();
        for (int c = 0; c < 2; c++)
            chk("switch", sw_exp(susp_sel ? op_l[c] : sus_l[c]), sw_got(c));
    endtask
    // write frame with expected acknowledges
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int cut, input logic ak);
        logic k0, k1;
        logic [7:0] q;
        i_smbus_host_model.txn(a, 1'b0, d, cut, k0, k1, q);
        chk("address ack", {7'h00, ak}, {7'h00, k0});
        if (cut == 8) chk("data ack", {7'h00, ak}, {7'h00, k1});
    endtask
    // read frame; an ignored read leaves the line released
    task automatic rd(input logic [6:0] a, input logic ak, input logic [7:0] e);
        logic k0, k1;
        logic [7:0] q;
        i_smbus_host_model.txn(a, 1'b1, 8'hFF, 8, k0, k1, q);
        chk("read ack", {7'h00, ak}, {7'h00, k0});
        chk("read data", ak ? e : 8'hFF, q);
    endtask
    // main sequence
    initial begin
        logic [7:0] d;
        logic [6:0] base;
        int ch;
        rst_b_in = 1'b0;
        strap = 1'b0;
        susp_sel = 1'b1;
        ovc = 4'h0;
        cat = 1'b0;
        op_l = '{8'h00, 8'h00};
        sus_l = '{8'h00, 8'h00};
        repeat (6) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        check_sw();
        // random commands on both straps, channels and latches
        for (int i = 0; i < 12; i++) begin
            strap = 1'($random(seed));
            ch = 32'($random(seed)) & 1;
            d = i < 2 ? (i ? 8'h7F : 8'hFF) : 8'($random(seed));
            base = strap ? 7'h52 : 7'h50;
            wr(base | 7'(ch), d, 8, 1'b1);
            if (d[7]) op_l[ch] = d; else sus_l[ch] = d;
            check_sw();
            wr((base ^ 7'h02) | 7'(ch), ~d, 8, 1'b0);
            check_sw();
            @(negedge sys_clk_in) susp_sel = ~susp_sel;
            repeat (8) @(negedge sys_clk_in);
            check_sw();
        end
        wr(7'h0C, 8'hFF, 8, 1'b0);
        wr(base, 8'hFF, 5, 1'b1);
        check_sw();
        // fault latch, return address and clear on read
        @(negedge sys_clk_in) strap = 1'b0;
        wr(7'h50, 8'h80, 8, 1'b1);
        op_l[0] = 8'h80;
        ovc = 4'b1010;
        cat = 1'b1;
        repeat (20) @(negedge sys_clk_in);
        ovc = 4'h0;
        cat = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        chk("alert", 8'h01, {7'h00, aoe});
        rd(7'h0C, 1'b1, 8'hA0);
        chk("alert", 8'h00, {7'h00, aoe});
        rd(7'h51, 1'b0, 8'hFF);
        rd(7'h50, 1'b1, 8'hD0);
        rd(7'h50, 1'b1, 8'h00);
        // masked alerts stay quiet
        wr(7'h50, 8'h81, 8, 1'b1);
        op_l[0] = 8'h81;
        cat = 1'b1;
        repeat (20) @(negedge sys_clk_in);
        chk("masked alert", 8'h00, {7'h00, aoe});
        check_sw();
        // unmask with the fault still present, then re-assert after read
        wr(7'h50, 8'h80, 8, 1'b1);
        op_l[0] = 8'h80;
        repeat (4) @(negedge sys_clk_in);
        chk("unmasked alert", 8'h01, {7'h00, aoe});
        rd(7'h0C, 1'b1, 8'hA0);
        chk("alert again", 8'h01, {7'h00, aoe});
        tally_and_finish();
    end
endmodule
`default_nettype wire
